// >>> rtl/awr_pkg.sv
// Purpose: Shared constants for the application watchdog and run flag block
// Assumes: 8-bit register port, 25 MHz system clock
// Notes:   Register offsets are the byte addresses of the register port
package awr_pkg;
	localparam logic [7:0] AWR_OFS_ACTION  = 8'h23;
	localparam logic [7:0] AWR_OFS_GRACE   = 8'h24;
	localparam logic [7:0] AWR_OFS_COMMIT  = 8'h25;
	localparam logic [7:0] AWR_OFS_COUNT   = 8'h30;
	localparam logic [7:0] AWR_OFS_RUNNING = 8'h31;

	localparam logic [7:0] AWR_ACT_OFF      = 8'h00;
	localparam logic [7:0] AWR_ACT_ALERT    = 8'h01;
	localparam logic [7:0] AWR_ACT_POWEROFF = 8'h02;

	localparam logic [7:0] AWR_RST_ACTION = 8'h00;
	localparam logic [7:0] AWR_RST_GRACE  = 8'h02;
	localparam logic [7:0] AWR_RST_COUNT  = 8'h00;
	localparam logic [7:0] AWR_COMMIT_KEY = 8'h46;
	localparam logic [7:0] AWR_ZERO       = 8'h00;

	// Watchdog step and system clock
	localparam int AWR_STEP_S     = 10;
	localparam int AWR_CLK_HZ     = 25000000;
	localparam int AWR_STEP_TICKS = AWR_STEP_S * AWR_CLK_HZ;

	// Host power states
	typedef enum logic [1:0] {
		AWR_OFF  = 2'b00,
		AWR_BOOT = 2'b01,
		AWR_RUN  = 2'b11,
		AWR_SHDN = 2'b10
	} awr_state_e;

	// Power indicator patterns
	typedef enum logic [1:0] {
		AWR_LED_DARK   = 2'b00,
		AWR_LED_PULSE  = 2'b01,
		AWR_LED_STEADY = 2'b10,
		AWR_LED_ERROR  = 2'b11
	} awr_led_e;
endpackage : awr_pkg

// >>> rtl/awr_step_div.sv
// Purpose: Divides the system clock down to one-cycle watchdog step pulses
// Assumes: Single clock domain
// Notes:   Restart realigns the step to a fresh full period
`timescale 1ns/1ns
module awr_step_div #(
	parameter int TICKS = awr_pkg::AWR_STEP_TICKS
) (
	// System
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic run,
	input  wire logic restart,
	// Output
	output logic      step
);
	import awr_pkg::*;

	logic [31:0] cnt_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 32'h0;
		end else if (restart || !run) begin
			cnt_q <= 32'h0;
		end else if (cnt_q == 32'(TICKS - 1)) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	assign step = run && !restart && (cnt_q == 32'(TICKS - 1));
endmodule : awr_step_div

// >>> rtl/awr_nv_store.sv
// Purpose: Nonvolatile copy of the flash-backed configuration
// Assumes: Contents survive rst, which stands for a full power loss
// Notes:   Read data come from a register; start-up values are the register reset defaults
`timescale 1ns/1ns
module awr_nv_store (
	// System
	input  wire logic       clk,
	// Write side
	input  wire logic       commit,
	input  wire logic [7:0] action_in,
	input  wire logic [7:0] grace_in,
	// Read side
	output logic      [7:0] action_out,
	output logic      [7:0] grace_out
);
	import awr_pkg::*;

	// No reset: committed values must outlive a power loss
	logic [7:0] mem_action_q = AWR_RST_ACTION;
	logic [7:0] mem_grace_q  = AWR_RST_GRACE;

	always_ff @(posedge clk) begin
		if (commit) begin
			mem_action_q <= action_in;
			mem_grace_q  <= grace_in;
		end
	end

	// Free-running copy so the restore after reset sees the stored word
	always_ff @(posedge clk) begin
		action_out <= mem_action_q;
		grace_out  <= mem_grace_q;
	end
endmodule : awr_nv_store

// >>> rtl/awr_watchdog.sv
// Purpose: Application watchdog, host running flag and configuration commit
// Assumes: Register port decoded upstream from the serial link; pins synchronised here
// Notes:   rst is a full power loss; host power-off alone keeps settings
`timescale 1ns/1ns
module awr_watchdog #(
	parameter int STEP_TICKS = awr_pkg::AWR_STEP_TICKS
) (
	// System
	input  wire logic       clk,
	input  wire logic       rst,
	// Register port
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// Power and pins
	input  wire logic       host_power_req,
	input  wire logic       button_pin,
	input  wire logic       battery_low_pin,
	input  wire logic       shutdown_done_pin,
	output logic            host_power_en,
	output logic            shutdown_request,
	output awr_pkg::awr_led_e power_indicator
);
	import awr_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {shutdown_done_pin, battery_low_pin, button_pin};
			sync2_q <= sync1_q;
		end
	end

	logic button_s;
	logic batt_low_s;
	logic done_s;
	logic button_prev_q;
	logic button_press;

	assign button_s   = sync2_q[0];
	assign batt_low_s = sync2_q[1];
	assign done_s     = sync2_q[2];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			button_prev_q <= 1'b0;
		end else begin
			button_prev_q <= button_s;
		end
	end

	assign button_press = button_s && !button_prev_q;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return reg_wr && (a == ofs);
	endfunction : hit

	logic wr_action;
	logic wr_grace;
	logic wr_commit;
	logic wr_count;
	logic wr_running;

	assign wr_action  = hit(reg_addr, AWR_OFS_ACTION);
	assign wr_grace   = hit(reg_addr, AWR_OFS_GRACE);
	assign wr_commit  = hit(reg_addr, AWR_OFS_COMMIT);
	assign wr_count   = hit(reg_addr, AWR_OFS_COUNT);
	assign wr_running = hit(reg_addr, AWR_OFS_RUNNING);

	// ----------------------------------------
	// Configuration and flash copy
	// ----------------------------------------
	logic [7:0] action_q;
	logic [7:0] grace_q;
	logic [7:0] nv_action;
	logic [7:0] nv_grace;
	logic       commit;
	logic       restore_q;

	assign commit = wr_commit && (reg_wdata == AWR_COMMIT_KEY);

	awr_nv_store u_nv (
		.clk        (clk),
		.commit     (commit),
		.action_in  (action_q),
		.grace_in   (grace_q),
		.action_out (nv_action),
		.grace_out  (nv_grace)
	);

	// One cycle after power returns the committed copy is loaded
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restore_q <= 1'b1;
		end else begin
			restore_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			action_q <= AWR_RST_ACTION;
			grace_q  <= AWR_RST_GRACE;
		end else if (restore_q) begin
			action_q <= nv_action;
			grace_q  <= nv_grace;
		end else begin
			if (wr_action) begin
				action_q <= reg_wdata;
			end
			if (wr_grace) begin
				grace_q <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// Host power state
	// ----------------------------------------
	awr_state_e state_q;
	logic       running_q;
	logic       wd_fire_off;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= AWR_OFF;
		end else begin
			unique case (state_q)
				AWR_OFF: begin
					if (host_power_req) begin
						state_q <= AWR_BOOT;
					end
				end
				AWR_BOOT: begin
					if (wr_running && reg_wdata != AWR_ZERO) begin
						state_q <= AWR_RUN;
					end
				end
				AWR_RUN: begin
					if (!running_q || wd_fire_off) begin
						state_q <= AWR_SHDN;
					end
				end
				AWR_SHDN: begin
					if (done_s) begin
						state_q <= AWR_OFF;
					end
				end
			endcase
		end
	end

	// Clears win over the host's own set in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			running_q <= 1'b0;
		end else if (state_q == AWR_OFF || state_q == AWR_SHDN) begin
			running_q <= 1'b0;
		end else if (state_q == AWR_RUN && (button_press || batt_low_s)) begin
			running_q <= 1'b0;
		end else if (state_q == AWR_BOOT && batt_low_s) begin
			running_q <= 1'b0;
		end else if (wr_running) begin
			running_q <= (reg_wdata != AWR_ZERO);
		end
	end

	logic boot_done;

	assign boot_done = (state_q == AWR_BOOT) && wr_running && (reg_wdata != AWR_ZERO) && !batt_low_s;

	// ----------------------------------------
	// Watchdog countdown
	// ----------------------------------------
	logic [7:0] count_q;
	logic       expired_q;
	logic       alert_q;
	logic       step;
	logic       enabled;

	assign enabled = (action_q != AWR_ACT_OFF);

	awr_step_div #(
		.TICKS (STEP_TICKS)
	) u_div (
		.clk     (clk),
		.rst     (rst),
		.run     (enabled && count_q != AWR_ZERO),
		.restart (wr_count || boot_done),
		.step    (step)
	);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= AWR_RST_COUNT;
		end else if (wr_count) begin
			count_q <= reg_wdata;
		end else if (boot_done) begin
			count_q <= grace_q;
		end else if (step) begin
			count_q <= count_q - 8'h01;
		end
	end

	// Reaching zero fires once; a fresh nonzero load rearms
	logic fire;

	assign fire = step && (count_q == 8'h01) && !wr_count && !boot_done && !expired_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			expired_q <= 1'b0;
		end else if (fire) begin
			expired_q <= 1'b1;
		end else if ((wr_count && reg_wdata != AWR_ZERO) || boot_done) begin
			expired_q <= 1'b0;
		end
	end

	assign wd_fire_off = fire && (action_q == AWR_ACT_POWEROFF);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alert_q <= 1'b0;
		end else if (fire && action_q == AWR_ACT_ALERT) begin
			alert_q <= 1'b1;
		end else if (state_q == AWR_OFF || (wr_count && reg_wdata != AWR_ZERO)) begin
			alert_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_indicator  <= AWR_LED_DARK;
			host_power_en    <= 1'b0;
			shutdown_request <= 1'b0;
		end else begin
			host_power_en    <= (state_q != AWR_OFF);
			shutdown_request <= (state_q == AWR_SHDN);
			if (state_q == AWR_OFF) begin
				power_indicator <= AWR_LED_DARK;
			end else if (state_q == AWR_RUN && alert_q) begin
				power_indicator <= AWR_LED_ERROR;
			end else if (state_q == AWR_RUN) begin
				power_indicator <= AWR_LED_STEADY;
			end else begin
				power_indicator <= AWR_LED_PULSE;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= AWR_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				AWR_OFS_ACTION:  reg_rdata <= action_q;
				AWR_OFS_GRACE:   reg_rdata <= grace_q;
				AWR_OFS_COUNT:   reg_rdata <= count_q;
				AWR_OFS_RUNNING: reg_rdata <= {7'h0, running_q};
				default:         reg_rdata <= AWR_ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_off_holds: assert property (@(posedge clk) disable iff (rst)
		!enabled && !wr_count && !boot_done |=> count_q == $past(count_q))
		else $error("countdown moved while disabled");
	a_step_dec: assert property (@(posedge clk) disable iff (rst)
		step && !wr_count && !boot_done |=> count_q == $past(count_q) - 8'h01)
		else $error("step did not decrement");
	a_grace_load: assert property (@(posedge clk) disable iff (rst)
		boot_done && !wr_count |=> count_q == $past(grace_q))
		else $error("grace not loaded");
	a_count_write: assert property (@(posedge clk) disable iff (rst)
		wr_count |=> count_q == $past(reg_wdata))
		else $error("countdown write lost");
	a_zero_holds: assert property (@(posedge clk) disable iff (rst)
		count_q == AWR_ZERO && !wr_count && !boot_done |=> count_q == AWR_ZERO)
		else $error("countdown left zero on its own");
	a_flag_off: assert property (@(posedge clk) disable iff (rst)
		state_q == AWR_OFF |=> !running_q)
		else $error("flag set while host off");
	a_button_clr: assert property (@(posedge clk) disable iff (rst)
		state_q == AWR_RUN && button_press |=> !running_q)
		else $error("button did not clear flag");
	a_alert_led: assert property (@(posedge clk) disable iff (rst)
		fire && action_q == AWR_ACT_ALERT && state_q == AWR_RUN && !running_q == 1'b0
		|=> ##1 power_indicator == AWR_LED_ERROR || state_q != AWR_RUN)
		else $error("no error flash on expiry");
	a_poweroff_act: assert property (@(posedge clk) disable iff (rst)
		state_q == AWR_RUN && wd_fire_off |=> state_q == AWR_SHDN ##1 shutdown_request)
		else $error("no shutdown on expiry");
	a_shdn_done: assert property (@(posedge clk) disable iff (rst)
		state_q == AWR_SHDN && done_s |=> ##1 !host_power_en)
		else $error("power kept after shutdown");
	a_commit_key: assert property (@(posedge clk) disable iff (rst)
		commit |=> ##1 nv_grace == $past(grace_q, 2) && nv_action == $past(action_q, 2))
		else $error("commit not stored");
endmodule : awr_watchdog

// >>> sim/awr_host_model.sv
// Purpose: Host software model on the register port
// Assumes: Callers enter tasks 1 ns after a rising edge
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/1ns
module awr_host_model (
	// System
	input  wire logic       clk,
	// Register port
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	// Power
	output logic            host_power_req,
	output logic            shutdown_done_pin,
	input  wire logic       shutdown_request
);
	import awr_pkg::*;
	int done_delay = 0;
	int held       = 0;
	initial begin
		reg_wr            = 1'b0;
		reg_rd            = 1'b0;
		reg_addr          = 8'h00;
		reg_wdata         = 8'h00;
		host_power_req    = 1'b0;
		shutdown_done_pin = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
		// Idle edge keeps back-to-back calls from re-driving in one step
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_rd   = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1;
		d        = reg_rdata;
		reg_rd   = 1'b0;
		reg_addr = ~a;
		@(posedge clk);
		#1;
	endtask : rd
	task automatic power_up();
		host_power_req = 1'b1;
		@(posedge clk);
		#1;
		host_power_req = 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : power_up
	task automatic announce_boot();
		wr(AWR_OFS_RUNNING, 8'h01);
	endtask : announce_boot
	task automatic service(input logic [7:0] n);
		wr(AWR_OFS_COUNT, n);
	endtask : service
	// Slow or prompt OS shutdown once asked
	always @(posedge clk) begin
		held              <= shutdown_request ? held + 1 : 0;
		shutdown_done_pin <= shutdown_request && held >= done_delay;
	end
endmodule : awr_host_model

// >>> sim/tb.sv
// Purpose: Self-checking bench for the watchdog and run flag block
// Assumes: Step shortened to STEP cycles
// Notes:   Fixed seed keeps random counts repeatable
`timescale 1ns/1ns
module tb;
	import awr_pkg::*;
	localparam int STEP = 20;
	logic       clk             = 1'b0;
	logic       rst             = 1'b1;
	logic       button_pin      = 1'b0;
	logic       battery_low_pin = 1'b0;
	logic       reg_wr, reg_rd, host_power_req, shutdown_done_pin;
	logic       host_power_en, shutdown_request;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, n, g, v;
	awr_led_e   power_indicator;
	int         fail_count      = 0;
	int         samples_checked = 0;
	int         seed            = 32'he9ed1234;
	always #20 clk = ~clk;
	awr_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_power_req(host_power_req),
		.shutdown_done_pin(shutdown_done_pin), .shutdown_request(shutdown_request));
	awr_watchdog #(.STEP_TICKS(STEP)) i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_power_req(host_power_req),
		.button_pin(button_pin), .battery_low_pin(battery_low_pin), .shutdown_done_pin(shutdown_done_pin),
		.host_power_en(host_power_en), .shutdown_request(shutdown_request), .power_indicator(power_indicator));
	function automatic logic [7:0] exp_count(input logic [7:0] c, input int k);
		return (k < c) ? c - 8'(k) : 8'h00;
	endfunction : exp_count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : cyc
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host.rd(a, d);
		chk(d, exp);
	endtask : rd_chk
	task automatic do_reset();
		rst = 1'b1;
		cyc(5);
		chk({4'h0, power_indicator, host_power_en, shutdown_request}, 8'h00);
		rst = 1'b0;
		cyc(2);
	endtask : do_reset
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done
	initial begin
		#(40 * 20000);
		fail_count++;
		test_done();
	end
	initial begin
		do_reset();
		rd_chk(AWR_OFS_ACTION, AWR_RST_ACTION);
		rd_chk(AWR_OFS_GRACE, AWR_RST_GRACE);
		rd_chk(AWR_OFS_COMMIT, 8'h00);
		rd_chk(AWR_OFS_RUNNING, 8'h00);
		rd_chk(8'h40, 8'h00);
		i_host.power_up();
		chk({6'h0, power_indicator}, {6'h0, AWR_LED_PULSE});
		rd_chk(AWR_OFS_RUNNING, 8'h00);
		i_host.announce_boot();
		cyc(2);
		chk({6'h0, power_indicator}, {6'h0, AWR_LED_STEADY});
		rd_chk(AWR_OFS_COUNT, AWR_RST_GRACE);
		cyc(3 * STEP);
		rd_chk(AWR_OFS_COUNT, AWR_RST_GRACE);
		// ----------------------------------------
		// Countdown to alert
		// ----------------------------------------
		i_host.wr(AWR_OFS_ACTION, AWR_ACT_ALERT);
		n = 8'(($random(seed) & 3) | 1);
		i_host.service(n);
		cyc(10);
		for (int k = 0; k <= n; k++) begin
			rd_chk(AWR_OFS_COUNT, exp_count(n, k));
			cyc(STEP - 1);
		end
		chk({6'h0, power_indicator}, {6'h0, AWR_LED_ERROR});
		cyc(3 * STEP);
		rd_chk(AWR_OFS_COUNT, 8'h00);
		chk({6'h0, power_indicator}, {6'h0, AWR_LED_ERROR});
		i_host.service(8'h03);
		cyc(2);
		chk({6'h0, power_indicator}, {6'h0, AWR_LED_STEADY});
		// Rewrite just before a step must restart the step
		cyc(15);
		i_host.service(8'h03);
		cyc(15);
		rd_chk(AWR_OFS_COUNT, 8'h03);
		i_host.wr(AWR_OFS_ACTION, AWR_ACT_OFF);
		cyc(3 * STEP);
		rd_chk(AWR_OFS_COUNT, 8'h03);
		// ----------------------------------------
		// Shutdown sources, grace kept across power-off
		// ----------------------------------------
		g = 8'($random(seed)) | 8'h04;
		i_host.wr(AWR_OFS_GRACE, g);
		for (int s = 0; s < 4; s++) begin
			i_host.done_delay = s * 7;
			if (s > 0) begin
				i_host.power_up();
				i_host.announce_boot();
				cyc(2);
				rd_chk(AWR_OFS_COUNT, g);
			end
			case (s)
				0: button_pin = 1'b1;
				1: battery_low_pin = 1'b1;
				2: i_host.wr(AWR_OFS_RUNNING, 8'h00);
				default: begin
					i_host.wr(AWR_OFS_ACTION, AWR_ACT_POWEROFF);
					i_host.service(8'h01);
				end
			endcase
			for (int t = 0; t < 4 * STEP && shutdown_request !== 1'b1; t++) cyc(1);
			chk({7'h0, shutdown_request}, 8'h01);
			chk({6'h0, power_indicator}, {6'h0, AWR_LED_PULSE});
			button_pin      = 1'b0;
			battery_low_pin = 1'b0;
			rd_chk(AWR_OFS_RUNNING, 8'h00);
			for (int t = 0; t < 100 && host_power_en !== 1'b0; t++) cyc(1);
			chk({7'h0, host_power_en}, 8'h00);
		end
		rd_chk(AWR_OFS_GRACE, g);
		// ----------------------------------------
		// Commit and power loss
		// ----------------------------------------
		v = AWR_COMMIT_KEY ^ (8'($random(seed)) | 8'h01);
		i_host.wr(AWR_OFS_COMMIT, v);
		rd_chk(AWR_OFS_COMMIT, 8'h00);
		do_reset();
		rd_chk(AWR_OFS_GRACE, AWR_RST_GRACE);
		i_host.wr(AWR_OFS_GRACE, g);
		i_host.wr(AWR_OFS_ACTION, AWR_ACT_ALERT);
		i_host.wr(AWR_OFS_COMMIT, AWR_COMMIT_KEY);
		i_host.wr(AWR_OFS_GRACE, g ^ 8'h01);
		rd_chk(AWR_OFS_COMMIT, 8'h00);
		do_reset();
		rd_chk(AWR_OFS_GRACE, g);
		rd_chk(AWR_OFS_ACTION, AWR_ACT_ALERT);
		test_done();
	end
endmodule : tb
